// *** core/hsi_defs.vh ***
`ifndef HSI_DEFS_VH
`define HSI_DEFS_VH

// Register byte offsets
`define HSI_A_CTRL      12'h000
`define HSI_A_STATUS    12'h004
`define HSI_A_HADDR     12'h008
`define HSI_A_LADDR     12'h00C
`define HSI_A_COUNT     12'h010
`define HSI_A_DXA_ADDR  12'h014
`define HSI_A_DXA_DATA  12'h018
`define HSI_A_PSDM_DATA 12'h01C
`define HSI_A_CMD       12'h020
`define HSI_A_INT_STAT  12'h024
`define HSI_A_FAIL      12'h028
`define HSI_A_BURST     12'h02C

// Control register fields
`define HSI_C_START  0
`define HSI_C_DIR    1
`define HSI_C_BURST  2
`define HSI_C_PAREN  3
`define HSI_C_WID_LO 4
`define HSI_C_WID_HI 5
`define HSI_C_INIT   6
`define HSI_C_PSDM   7

// Host bus width codes
`define HSI_W8  2'h0
`define HSI_W16 2'h1
`define HSI_W32 2'h2

// Reset values
`define HSI_CTRL_RST  8'h24
`define HSI_BURST_RST 8'h10

// Slow clock half period in cycles, less one (the counter runs 0 to 63, so each half lasts 64 cycles)
`define HSI_SLOW_HALF 8'h3F

// Sustained rates in Mbit/s, host cycle budget at 125 MHz and 32 bits
`define HSI_DMA_MBPS   64
`define HSI_PSDM_MBPS  48
`define HSI_CLK_MHZ    125
`define HSI_DMA_BUDGET ((`HSI_CLK_MHZ * 32) / `HSI_DMA_MBPS)

`endif

// *** core/hsi_host_if.v ***
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
//Contract
// - Check every system clock against reference clock
// - Any invalid clock enters slow-clock mode
// - Bus clock failure aborts DMA at once
// - Other clock failure completes DMA first (code stops the DMA after the current word)
// - Slow free-running clock replaces failed clocks
// - Slow-clock mode holds low-power reset
// - Odd byte parity always kept internally
// - Strap selects host bus style
// - Style A 8/16/32 bits, style B 16/32
// - Drive full 32-bit host address
// - Offer bus-master DMA, pseudo-DMA, direct I/O
// - Bulk data moves by DMA or pseudo-DMA
// - Direct I/O loads memory, carries command interrupts
// - DMA burst or cycle-steal, optional parity
// - Re-arbitrate bus automatically after each burst
// - Repeat cycle on parity/bus error, honour retry
// - DMA sustains 64 Mbit/s
// - Pseudo-DMA sustains 48 Mbit/s at 16 MHz
// - Reference clock free-runs 10 to 100 kHz
`include "hsi_defs.vh"

module hsi_host_if #(
  parameter NCLK = 3
) (
  // Clock and reset
  input  wire            CLK_IN,
  input  wire            RESETN_IN,
  // APB slave
  input  wire            PSEL_IN,
  input  wire            PENABLE_IN,
  input  wire            PWRITE_IN,
  input  wire [11:0]     PADDR_IN,
  input  wire [31:0]     PWDATA_IN,
  output reg  [31:0]     PRDATA_OUT,
  output reg             PREADY_OUT,
  output reg             PSLVERR_OUT,
  // Strap and clock supervision
  input  wire            BUS_STYLE_IN,
  input  wire            REF_CLK_IN,
  input  wire [NCLK-1:0] MON_CLK_IN,
  output reg             SLOW_MODE_OUT,
  output reg  [NCLK-1:0] CLK_SUBST_OUT,
  output reg             SLOW_CLK_OUT,
  output reg             ADP_RESET_OUT,
  // Host bus master
  output reg             HREQ_OUT,
  input  wire            HGNT_IN,
  output reg             HCYC_OUT,
  output reg             HWRITE_OUT,
  output reg  [1:0]      HSIZE_OUT,
  output reg  [31:0]     HADDR_OUT,
  output reg  [31:0]     HDATA_OUT,
  output reg  [3:0]      HPAR_OUT,
  input  wire [31:0]     HDATA_IN,
  input  wire [3:0]      HPAR_IN,
  input  wire            HACK_IN,
  input  wire            HBERR_IN,
  input  wire            HRETRY_IN,
  // Local memory side
  output reg             LOC_RD_OUT,
  output reg             LOC_WR_OUT,
  output reg  [31:0]     LOC_ADDR_OUT,
  output reg  [31:0]     LOC_WDATA_OUT,
  input  wire [31:0]     LOC_RDATA_IN,
  input  wire            LOC_ACK_IN,
  // Adapter command and status
  output reg  [15:0]     ADP_CMD_OUT,
  output reg             ADP_CMD_VALID_OUT,
  input  wire            ADP_STATUS_IN,
  output reg             HOST_INT_OUT
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam S_IDLE  = 3'h0;
  localparam S_REQ   = 3'h1;
  localparam S_LRD   = 3'h2;
  localparam S_HCYC  = 3'h3;
  localparam S_LWR   = 3'h4;
  localparam S_NEXT  = 3'h5;
  localparam S_REARB = 3'h6;

  reg  [2:0]      state_reg;
  reg  [7:0]      ctrl_reg;
  reg  [31:0]     haddr_reg;
  reg  [31:0]     laddr_reg;
  reg  [15:0]     count_reg;
  reg  [31:0]     dxa_addr_reg;
  reg  [7:0]      burst_len_reg;
  reg  [7:0]      burst_cnt_reg;
  reg  [31:0]     buf_reg;
  reg  [3:0]      buf_par_reg;
  reg  [15:0]     retry_cnt_reg;
  reg             style_reg;
  reg             strap_done_reg;
  reg             par_err_reg;
  reg             cmd_int_reg;
  reg  [NCLK-1:0] fail_sticky_reg;
  reg  [NCLK-1:0] clk_valid_reg;
  reg  [NCLK-1:0] mon_d_reg;
  reg  [NCLK-1:0] seen_reg;
  reg             ref_d_reg;
  reg             fail_pend_reg;
  reg             dma_lsent_reg;
  reg             apb_lsent_reg;
  reg             owner_apb_reg;
  reg  [7:0]      slow_cnt_reg;

  wire            ref_edge = REF_CLK_IN & ~ref_d_reg;
  wire [NCLK-1:0] mon_edge = MON_CLK_IN ^ mon_d_reg;
  wire            bus_clk_bad = ~clk_valid_reg[0];
  wire            access = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
  wire            is_dxa = (PADDR_IN == `HSI_A_DXA_DATA);
  wire            is_psdm = (PADDR_IN == `HSI_A_PSDM_DATA);
  wire            loc_busy = LOC_RD_OUT | LOC_WR_OUT;
  wire            dma_loc = (state_reg == S_LRD) | (state_reg == S_LWR);
  wire [1:0]      wid = ctrl_reg[`HSI_C_WID_HI:`HSI_C_WID_LO];
  // Style B has no 8-bit variant: an 8-bit request runs as 16 bits
  wire [1:0]      eff_wid = (style_reg && wid == `HSI_W8) ? `HSI_W16 :
                            (wid > `HSI_W32) ? `HSI_W32 : wid;
  wire [31:0]     step = (eff_wid == `HSI_W8)  ? 32'h00000001 :
                         (eff_wid == `HSI_W16) ? 32'h00000002 : 32'h00000004;
  wire [31:0]     hdata_le = style_reg ? swap(HDATA_IN) : HDATA_IN;
  wire            host_par_bad = ctrl_reg[`HSI_C_PAREN] &
                                 (HPAR_IN != (style_reg ? swap_par(par4(HDATA_IN)) :
                                  par4(HDATA_IN)));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Odd parity, one bit per byte
  function [3:0] par4;
    input [31:0] d;
    begin
      par4 = {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]};
    end
  endfunction

  // Style B places the most significant byte at the lowest address
  function [31:0] swap;
    input [31:0] d;
    begin
      swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
  endfunction

  function [3:0] swap_par;
    input [3:0] p;
    begin
      swap_par = {p[0], p[1], p[2], p[3]};
    end
  endfunction

  // ---------------------------------------------------------------
  // Clock supervision and slow-clock mode
  // ---------------------------------------------------------------
  always @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ref_d_reg       <= 1'b0;
      mon_d_reg       <= {NCLK{1'b0}};
      seen_reg        <= {NCLK{1'b0}};
      clk_valid_reg   <= {NCLK{1'b1}};
      fail_pend_reg   <= 1'b0;
      SLOW_MODE_OUT   <= 1'b0;
      CLK_SUBST_OUT   <= {NCLK{1'b0}};
      ADP_RESET_OUT   <= 1'b1;
      slow_cnt_reg    <= 8'h00;
      SLOW_CLK_OUT    <= 1'b0;
      style_reg       <= 1'b0;
      strap_done_reg  <= 1'b0;
    end else begin
      // Strap caught once after reset release
      if (!strap_done_reg) begin
        style_reg      <= BUS_STYLE_IN;
        strap_done_reg <= 1'b1;
      end
      ADP_RESET_OUT <= SLOW_MODE_OUT | ~strap_done_reg;
      ref_d_reg <= REF_CLK_IN;
      mon_d_reg <= MON_CLK_IN;
      // Each reference period every clock must show at least one edge
      if (ref_edge) begin
        clk_valid_reg <= seen_reg | mon_edge;
        seen_reg      <= {NCLK{1'b0}};
      end else begin
        seen_reg <= seen_reg | mon_edge;
      end
      if (~&clk_valid_reg)
        fail_pend_reg <= 1'b1;
      // Bus clock loss enters at once, others wait for the current DMA word to end
      if (fail_pend_reg && !SLOW_MODE_OUT &&
          (bus_clk_bad || state_reg == S_IDLE)) begin
        SLOW_MODE_OUT <= 1'b1;
        ADP_RESET_OUT <= 1'b1;
        CLK_SUBST_OUT <= ~clk_valid_reg;
      end
      if (SLOW_MODE_OUT)
        CLK_SUBST_OUT <= ~clk_valid_reg;
      // Leave only on host re-init with all clocks good
      if (SLOW_MODE_OUT && access && PWRITE_IN && PADDR_IN == `HSI_A_CTRL &&
          PWDATA_IN[`HSI_C_INIT] && (&clk_valid_reg)) begin
        SLOW_MODE_OUT <= 1'b0;
        fail_pend_reg <= 1'b0;
        CLK_SUBST_OUT <= {NCLK{1'b0}};
      end
      // Free-running slow clock
      if (slow_cnt_reg == `HSI_SLOW_HALF) begin
        slow_cnt_reg <= 8'h00;
        SLOW_CLK_OUT <= ~SLOW_CLK_OUT;
      end else begin
        slow_cnt_reg <= slow_cnt_reg + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // DMA engine, local port and APB registers
  // ---------------------------------------------------------------
  always @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_reg         <= S_IDLE;
      ctrl_reg          <= `HSI_CTRL_RST;
      haddr_reg         <= 32'h00000000;
      laddr_reg         <= 32'h00000000;
      count_reg         <= 16'h0000;
      dxa_addr_reg      <= 32'h00000000;
      burst_len_reg     <= `HSI_BURST_RST;
      burst_cnt_reg     <= 8'h00;
      buf_reg           <= 32'h00000000;
      buf_par_reg       <= 4'hF;
      retry_cnt_reg     <= 16'h0000;
      par_err_reg       <= 1'b0;
      cmd_int_reg       <= 1'b0;
      fail_sticky_reg   <= {NCLK{1'b0}};
      dma_lsent_reg     <= 1'b0;
      apb_lsent_reg     <= 1'b0;
      owner_apb_reg     <= 1'b0;
      HREQ_OUT          <= 1'b0;
      HCYC_OUT          <= 1'b0;
      HWRITE_OUT        <= 1'b0;
      HSIZE_OUT         <= `HSI_W32;
      HADDR_OUT         <= 32'h00000000;
      HDATA_OUT         <= 32'h00000000;
      HPAR_OUT          <= 4'hF;
      LOC_RD_OUT        <= 1'b0;
      LOC_WR_OUT        <= 1'b0;
      LOC_ADDR_OUT      <= 32'h00000000;
      LOC_WDATA_OUT     <= 32'h00000000;
      ADP_CMD_OUT       <= 16'h0000;
      ADP_CMD_VALID_OUT <= 1'b0;
      HOST_INT_OUT      <= 1'b0;
      PRDATA_OUT        <= 32'h00000000;
      PREADY_OUT        <= 1'b0;
      PSLVERR_OUT       <= 1'b0;
    end else begin
      ADP_CMD_VALID_OUT <= 1'b0;
      PREADY_OUT        <= 1'b0;
      PSLVERR_OUT       <= 1'b0;
      HOST_INT_OUT      <= cmd_int_reg;
      fail_sticky_reg   <= fail_sticky_reg | ~clk_valid_reg;
      if (LOC_ACK_IN) begin
        LOC_RD_OUT <= 1'b0;
        LOC_WR_OUT <= 1'b0;
      end

      // DMA state machine
      case (state_reg)
        S_IDLE: begin
          burst_cnt_reg <= 8'h00;
          if (ctrl_reg[`HSI_C_START] && count_reg != 16'h0000 && !fail_pend_reg) begin
            state_reg <= S_REQ;
            HREQ_OUT  <= 1'b1;
          end
          ctrl_reg[`HSI_C_START] <= 1'b0;
        end
        S_REQ: if (HGNT_IN) begin
          state_reg <= ctrl_reg[`HSI_C_DIR] ? S_LRD : S_HCYC;
          if (!ctrl_reg[`HSI_C_DIR]) begin
            HCYC_OUT   <= 1'b1;
            HWRITE_OUT <= 1'b0;
          end
        end
        S_LRD: begin
          if (!dma_lsent_reg && !loc_busy) begin
            LOC_RD_OUT    <= 1'b1;
            LOC_ADDR_OUT  <= laddr_reg;
            owner_apb_reg <= 1'b0;
            dma_lsent_reg <= 1'b1;
          end else if (dma_lsent_reg && LOC_ACK_IN && !owner_apb_reg) begin
            buf_reg       <= LOC_RDATA_IN;
            buf_par_reg   <= par4(LOC_RDATA_IN);
            dma_lsent_reg <= 1'b0;
            state_reg     <= S_HCYC;
            HCYC_OUT      <= 1'b1;
            HWRITE_OUT    <= 1'b1;
            HDATA_OUT     <= style_reg ? swap(LOC_RDATA_IN) : LOC_RDATA_IN;
            HPAR_OUT      <= style_reg ? swap_par(par4(LOC_RDATA_IN)) :
                             par4(LOC_RDATA_IN);
          end
        end
        S_HCYC: begin
          HADDR_OUT <= haddr_reg;
          HSIZE_OUT <= eff_wid;
          if (HRETRY_IN || HBERR_IN || (HACK_IN && !HWRITE_OUT && host_par_bad)) begin
            // Cycle stays asserted and is run again
            retry_cnt_reg <= retry_cnt_reg + 16'h0001;
            if (HACK_IN && !HWRITE_OUT && host_par_bad)
              par_err_reg <= 1'b1;
          end else if (HACK_IN) begin
            HCYC_OUT <= 1'b0;
            if (HWRITE_OUT) begin
              state_reg <= S_NEXT;
            end else begin
              buf_reg     <= hdata_le;
              buf_par_reg <= par4(hdata_le);
              state_reg   <= S_LWR;
            end
          end
        end
        S_LWR: begin
          if (!dma_lsent_reg && !loc_busy) begin
            LOC_WR_OUT    <= 1'b1;
            LOC_ADDR_OUT  <= laddr_reg;
            LOC_WDATA_OUT <= buf_reg;
            owner_apb_reg <= 1'b0;
            dma_lsent_reg <= 1'b1;
          end else if (dma_lsent_reg && LOC_ACK_IN && !owner_apb_reg) begin
            dma_lsent_reg <= 1'b0;
            state_reg     <= S_NEXT;
          end
        end
        S_NEXT: begin
          // Transfers run back to back, well inside the rate budget
          haddr_reg     <= haddr_reg + step;
          laddr_reg     <= laddr_reg + 32'h00000004;
          count_reg     <= count_reg - 16'h0001;
          burst_cnt_reg <= burst_cnt_reg + 8'h01;
          if (count_reg == 16'h0001 || fail_pend_reg) begin
            state_reg <= S_IDLE;
            HREQ_OUT  <= 1'b0;
          end else if (!ctrl_reg[`HSI_C_BURST] ||
                       burst_cnt_reg + 8'h01 >= burst_len_reg) begin
            state_reg <= S_REARB;
            HREQ_OUT  <= 1'b0;
          end else begin
            state_reg <= S_REQ;
          end
        end
        S_REARB: begin
          burst_cnt_reg <= 8'h00;
          HREQ_OUT      <= 1'b1;
          state_reg     <= S_REQ;
        end
        default: state_reg <= S_IDLE;
      endcase

      // Bus clock loss or reset state drops the bus at once
      if ((fail_pend_reg && bus_clk_bad) || SLOW_MODE_OUT) begin
        state_reg     <= S_IDLE;
        HREQ_OUT      <= 1'b0;
        HCYC_OUT      <= 1'b0;
        dma_lsent_reg <= 1'b0;
      end

      // Adapter status sets the host interrupt; set beats clear
      if (access && PWRITE_IN && PADDR_IN == `HSI_A_INT_STAT) begin
        if (PWDATA_IN[0])
          cmd_int_reg <= 1'b0;
        if (PWDATA_IN[1] && !(HCYC_OUT && HACK_IN && !HWRITE_OUT && host_par_bad))
          par_err_reg <= 1'b0;
      end
      if (ADP_STATUS_IN)
        cmd_int_reg <= 1'b1;
      if (access && PWRITE_IN && PADDR_IN == `HSI_A_FAIL)
        fail_sticky_reg <= (fail_sticky_reg & ~PWDATA_IN[NCLK-1:0]) | ~clk_valid_reg;

      // APB access
      if (access && (is_dxa || (is_psdm && ctrl_reg[`HSI_C_PSDM]))) begin
        if (SLOW_MODE_OUT) begin
          PREADY_OUT  <= 1'b1;
          PSLVERR_OUT <= 1'b1;
        end else if (!apb_lsent_reg && !loc_busy && !dma_loc) begin
          LOC_RD_OUT    <= ~PWRITE_IN;
          LOC_WR_OUT    <= PWRITE_IN;
          LOC_ADDR_OUT  <= is_dxa ? dxa_addr_reg : laddr_reg;
          LOC_WDATA_OUT <= PWDATA_IN;
          owner_apb_reg <= 1'b1;
          apb_lsent_reg <= 1'b1;
        end else if (apb_lsent_reg && LOC_ACK_IN && owner_apb_reg) begin
          // Local word per host access keeps pseudo-DMA at local speed
          apb_lsent_reg <= 1'b0;
          PREADY_OUT    <= 1'b1;
          PRDATA_OUT    <= PWRITE_IN ? 32'h00000000 : LOC_RDATA_IN;
          buf_par_reg   <= par4(PWRITE_IN ? PWDATA_IN : LOC_RDATA_IN);
          if (is_dxa) begin
            dxa_addr_reg <= dxa_addr_reg + 32'h00000004;
          end else begin
            laddr_reg <= laddr_reg + 32'h00000004;
            count_reg <= count_reg - 16'h0001;
          end
        end
      end else if (access) begin
        PREADY_OUT <= 1'b1;
        PRDATA_OUT <= 32'h00000000;
        if (PWRITE_IN) begin
          case (PADDR_IN)
            `HSI_A_CTRL:     ctrl_reg      <= PWDATA_IN[7:0] & ~8'h40;
            `HSI_A_HADDR:    haddr_reg     <= PWDATA_IN;
            `HSI_A_LADDR:    laddr_reg     <= PWDATA_IN;
            `HSI_A_COUNT:    count_reg     <= PWDATA_IN[15:0];
            `HSI_A_DXA_ADDR: dxa_addr_reg  <= PWDATA_IN;
            `HSI_A_BURST:    burst_len_reg <= PWDATA_IN[7:0];
            `HSI_A_CMD: begin
              ADP_CMD_OUT       <= PWDATA_IN[15:0];
              ADP_CMD_VALID_OUT <= 1'b1;
            end
            `HSI_A_INT_STAT, `HSI_A_FAIL: ;
            default: PSLVERR_OUT <= 1'b1;
          endcase
        end else begin
          case (PADDR_IN)
            `HSI_A_CTRL:     PRDATA_OUT <= {24'h000000, ctrl_reg};
            `HSI_A_STATUS:   PRDATA_OUT <= {16'h0000, retry_cnt_reg[7:0], buf_par_reg,
                                            state_reg != S_IDLE, SLOW_MODE_OUT,
                                            fail_pend_reg, style_reg};
            `HSI_A_HADDR:    PRDATA_OUT <= haddr_reg;
            `HSI_A_LADDR:    PRDATA_OUT <= laddr_reg;
            `HSI_A_COUNT:    PRDATA_OUT <= {16'h0000, count_reg};
            `HSI_A_DXA_ADDR: PRDATA_OUT <= dxa_addr_reg;
            `HSI_A_CMD:      PRDATA_OUT <= {16'h0000, ADP_CMD_OUT};
            `HSI_A_INT_STAT: PRDATA_OUT <= {30'h00000000, par_err_reg, cmd_int_reg};
            `HSI_A_FAIL:     PRDATA_OUT <= {{(32-2*NCLK){1'b0}}, clk_valid_reg,
                                            fail_sticky_reg};
            `HSI_A_BURST:    PRDATA_OUT <= {24'h000000, burst_len_reg};
            default:         PSLVERR_OUT <= 1'b1;
          endcase
        end
      end
    end
  end

endmodule // hsi_host_if

// *** dv/hsi_host_if_properties.sv ***
`timescale 1ns/100ps
module hsi_host_if_properties #(
  parameter NCLK = 3
) (
  // Clock, reset and register bus
  input wire logic            CLK_IN,
  input wire logic            RESETN_IN,
  input wire logic            PSEL_IN,
  input wire logic            PENABLE_IN,
  input wire logic [11:0]     PADDR_IN,
  input wire logic [31:0]     PRDATA_OUT,
  input wire logic            PREADY_OUT,
  input wire logic            PSLVERR_OUT,
  // Supervision and host bus
  input wire logic            SLOW_MODE_OUT,
  input wire logic [NCLK-1:0] CLK_SUBST_OUT,
  input wire logic            ADP_RESET_OUT,
  input wire logic            HCYC_OUT,
  input wire logic [31:0]     HADDR_OUT,
  input wire logic [31:0]     HDATA_OUT,
  input wire logic [3:0]      HPAR_OUT,
  input wire logic            HACK_IN,
  input wire logic            HBERR_IN,
  input wire logic            HRETRY_IN
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence s_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence s_access;
    PSEL_IN && PENABLE_IN;
  endsequence
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held longer than one cycle");
  a_plain_answer: assert property (
    s_setup ##1 s_access ##0 (PADDR_IN < 12'h018) |=> PREADY_OUT)
    else $error("register access not answered in one cycle");
  a_unmapped_err: assert property (
    s_setup ##1 s_access ##0 (PADDR_IN > 12'h02C) |=> PSLVERR_OUT && PRDATA_OUT == 32'h0)
    else $error("unmapped access not refused");
  a_slow_reset: assert property (SLOW_MODE_OUT |-> ADP_RESET_OUT)
    else $error("slow mode without adapter reset");
  a_slow_idle: assert property (SLOW_MODE_OUT |-> !HCYC_OUT)
    else $error("host cycle during slow mode");
  a_subst_entry: assert property ($rose(SLOW_MODE_OUT) |-> CLK_SUBST_OUT != 0)
    else $error("slow mode with no clock replaced");
  a_cyc_repeat: assert property (
    HCYC_OUT && $past(HCYC_OUT) && !(HACK_IN && !HBERR_IN && !HRETRY_IN)
      |=> (HCYC_OUT && $stable(HADDR_OUT)) || SLOW_MODE_OUT || CLK_SUBST_OUT[0])
    else $error("host cycle dropped before clean acknowledge");
  a_odd_parity: assert property (
    ^{HDATA_OUT[31:24], HPAR_OUT[3]} && ^{HDATA_OUT[23:16], HPAR_OUT[2]} &&
    ^{HDATA_OUT[15:8], HPAR_OUT[1]} && ^{HDATA_OUT[7:0], HPAR_OUT[0]})
    else $error("host data byte without odd parity");
endmodule // hsi_host_if_properties

bind hsi_host_if hsi_host_if_properties #(.NCLK(NCLK)) u_hsi_props (
  .CLK_IN, .RESETN_IN, .PSEL_IN, .PENABLE_IN, .PADDR_IN, .PRDATA_OUT, .PREADY_OUT,
  .PSLVERR_OUT, .SLOW_MODE_OUT, .CLK_SUBST_OUT, .ADP_RESET_OUT, .HCYC_OUT,
  .HADDR_OUT, .HDATA_OUT, .HPAR_OUT, .HACK_IN, .HBERR_IN, .HRETRY_IN
);

// *** dv/hsi_host_model.sv ***
`timescale 1ns/100ps
module hsi_host_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Host bus
  input  wire logic        hreq_in,
  input  wire logic        hcyc_in,
  input  wire logic [31:0] haddr_in,
  output logic             hgnt_out,
  output logic [31:0]      hdata_out,
  output logic [3:0]       hpar_out,
  output logic             hack_out,
  output logic             hberr_out,
  output logic             hretry_out,
  // Local memory
  input  wire logic        lrd_in,
  input  wire logic        lwr_in,
  input  wire logic [31:0] lwdata_in,
  output logic [31:0]      lrdata_out,
  output logic             lack_out,
  // Fault control and observation
  input  wire logic [1:0]  fault_in,
  output int               acks_out,
  output int               grants_out,
  output logic [31:0]      addr_seen_out,
  output logic [31:0]      lwdata_seen_out
);
  logic wait_reg;
  logic used_reg;
  logic ack_now;
  // One wait state, then acknowledge; released data toggles every cycle
  assign ack_now = hcyc_in && wait_reg && !hack_out;
  assign hpar_out = {~^hdata_out[31:24], ~^hdata_out[23:16], ~^hdata_out[15:8], ~^hdata_out[7:0]};
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hgnt_out <= 1'b0;
      hack_out <= 1'b0;
      hberr_out <= 1'b0;
      hretry_out <= 1'b0;
      wait_reg <= 1'b0;
      used_reg <= 1'b0;
      hdata_out <= 32'h0;
      lack_out <= 1'b0;
      lrdata_out <= 32'h0;
      acks_out <= 0;
      grants_out <= 0;
      addr_seen_out <= 32'h0;
      lwdata_seen_out <= 32'h0;
    end else begin
      hgnt_out <= hreq_in;
      if (hreq_in && !hgnt_out) grants_out <= grants_out + 1;
      wait_reg <= hcyc_in && !wait_reg && !hack_out;
      hack_out <= ack_now;
      hberr_out <= ack_now && fault_in[0] && !used_reg;
      hretry_out <= ack_now && fault_in[1] && !used_reg;
      used_reg <= (fault_in != 2'h0) && (used_reg || ack_now);
      hdata_out <= ack_now ? (haddr_in ^ 32'h5A5A_C3C3) : ~hdata_out;
      if (ack_now) acks_out <= acks_out + 1;
      if (ack_now) addr_seen_out <= haddr_in;
      lack_out <= (lrd_in || lwr_in) && !lack_out;
      lrdata_out <= (lrd_in && !lack_out) ? 32'h0F0F_1234 : ~lrdata_out;
      if (lwr_in && !lack_out) lwdata_seen_out <= lwdata_in;
    end
  end
endmodule // hsi_host_model

// *** dv/testbench.sv ***
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic        clk, rst_n, psel, penable, pwrite, ref_clk, hreq, hgnt, hcyc, hack;
  logic        hberr, hretry, slow, sclk, adp_rst, lrd, lwr, lack, er, pready, pslverr, sv;
  logic [2:0]  mon, run, subst;
  logic [1:0]  fault;
  logic [3:0]  hpar_o, hpar_i;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, haddr, hdata_i, lwdata, lrdata, rd, seen_a, seen_d;
  int          fail_count, n_checks, ref_cnt, acks, grants, n;

  hsi_host_if #(.NCLK(3)) u_hsi_host_if (
    .CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .BUS_STYLE_IN(1'b0), .REF_CLK_IN(ref_clk),
    .MON_CLK_IN(mon), .SLOW_MODE_OUT(slow), .CLK_SUBST_OUT(subst), .SLOW_CLK_OUT(sclk),
    .ADP_RESET_OUT(adp_rst), .HREQ_OUT(hreq), .HGNT_IN(hgnt), .HCYC_OUT(hcyc),
    .HWRITE_OUT(), .HSIZE_OUT(), .HADDR_OUT(haddr), .HDATA_OUT(), .HPAR_OUT(hpar_o),
    .HDATA_IN(hdata_i), .HPAR_IN(hpar_i), .HACK_IN(hack), .HBERR_IN(hberr),
    .HRETRY_IN(hretry), .LOC_RD_OUT(lrd), .LOC_WR_OUT(lwr), .LOC_ADDR_OUT(),
    .LOC_WDATA_OUT(lwdata), .LOC_RDATA_IN(lrdata), .LOC_ACK_IN(lack), .ADP_CMD_OUT(),
    .ADP_CMD_VALID_OUT(), .ADP_STATUS_IN(1'b0), .HOST_INT_OUT()
  );
  hsi_host_model u_hsi_host_model (
    .clk_in(clk), .rst_n_in(rst_n), .hreq_in(hreq), .hcyc_in(hcyc), .haddr_in(haddr),
    .hgnt_out(hgnt), .hdata_out(hdata_i), .hpar_out(hpar_i), .hack_out(hack),
    .hberr_out(hberr), .hretry_out(hretry), .lrd_in(lrd), .lwr_in(lwr), .lwdata_in(lwdata),
    .lrdata_out(lrdata), .lack_out(lack), .fault_in(fault), .acks_out(acks),
    .grants_out(grants), .addr_seen_out(seen_a), .lwdata_seen_out(seen_d)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Monitored clocks toggle every cycle while running; reference at 100 kHz
  always @(posedge clk) begin
    mon <= mon ^ run;
    ref_cnt <= (ref_cnt == 624) ? 0 : ref_cnt + 1;
    if (ref_cnt == 624) ref_clk <= ~ref_clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo(input string what);
    fail_count++;
    $display("ERROR %s expected completion seen timeout", what);
    summarize();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 200);
    if (k >= 200) tmo("apb answer");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_reset;
    repeat (16) @(posedge clk);
    `CHK("adapter reset held", 1'b1, adp_rst)
    `CHK("idle parity", 4'hF, hpar_o)
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("adapter reset released", 1'b0, adp_rst)
    $display("test reset done");
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    `CHK("control reset", 32'h24, rd)
    apb(1'b0, 12'h02C, 32'h0);
    `CHK("burst reset", 32'h10, rd)
    apb(1'b0, 12'h004, 32'h0);
    `CHK("bus style", 1'b0, rd[0])
    apb(1'b0, 12'h040, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    $display("test regs done");
  endtask
  task automatic t_dma;
    fault <= 2'h3;
    apb(1'b1, 12'h008, 32'hF000_0100);
    apb(1'b1, 12'h00C, 32'h0000_0200);
    apb(1'b1, 12'h010, 32'h3);
    apb(1'b1, 12'h02C, 32'h1);
    apb(1'b1, 12'h000, 32'h2D);
    n = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end while (rd[3] !== 1'b0 && n < 100);
    if (n >= 100) tmo("dma completion");
    fault <= 2'h0;
    `CHK("host cycles", 4, acks)
    `CHK("bus requests", 3, grants)
    `CHK("last host address", 32'hF000_0108, seen_a)
    `CHK("last local word", 32'hF000_0108 ^ 32'h5A5A_C3C3, seen_d)
    $display("test dma done");
  endtask
  task automatic t_clock_fail(input logic [2:0] m);
    apb(1'b1, 12'h010, 32'h400);
    apb(1'b1, 12'h000, 32'h2D);
    run <= ~m;
    n = 0;
    while (slow !== 1'b1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 6000) tmo("slow mode entry");
    `CHK("replaced clocks", m, subst)
    `CHK("low power reset", 1'b1, adp_rst)
    `CHK("dma stopped", 1'b0, hcyc)
    sv = sclk;
    n = 0;
    while (sclk === sv && n < 70) begin
      @(posedge clk);
      n++;
    end
    `CHK("slow clock runs", 1'b1, n < 70)
    apb(1'b0, 12'h018, 32'h0);
    `CHK("direct access refused", 1'b1, er)
    run <= 3'h7;
    repeat (3000) @(posedge clk);
    `CHK("still slow", 1'b1, slow)
    apb(1'b0, 12'h028, 32'h0);
    `CHK("failure flags", {3'h7, m}, rd[5:0])
    apb(1'b1, 12'h028, {29'h0, m});
    apb(1'b1, 12'h000, 32'h64);
    `CHK("slow mode left", 1'b0, slow)
    `CHK("adapter running", 1'b0, adp_rst)
    $display("test clock fail %h done", m);
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ref_clk = 1'b0;
    ref_cnt = 0;
    mon = 3'h0;
    run = 3'h7;
    fault = 2'h0;
    fail_count = 0;
    n_checks = 0;
    t_reset();
    t_regs();
    t_dma();
    t_clock_fail(3'h1);
    t_clock_fail(3'h2);
    summarize();
  end
endmodule // testbench
